/* File: hw/sfd_pkg.sv */
// Package of constants for the SPI frame handler and diagnosis word.
// Assumes a 200 MHz system clock sampling the host's serial pins.
package sfd_pkg;
	localparam int FRAME_BITS = 16;
	localparam int BYTE_BITS = 8;
	// Frame fields
	localparam int POS_WR = 15;
	localparam int POS_BANK = 14;
	localparam int POS_ADDR_HI = 13;
	localparam int POS_ADDR_LO = 8;
	localparam int POS_DIAG_REQ = 0;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	// Diagnosis word bit positions
	localparam int DG_SOFTRST_GUV = 14;
	localparam int DG_SUPPLY_UV = 13;
	localparam int DG_STATE_HI = 12;
	localparam int DG_STATE_LO = 11;
	localparam int DG_XFER_ERR = 10;
	localparam int DG_MON = 9;
	localparam int DG_MFS = 8;
	localparam int DG_CAL = 7;
	localparam int DG_VINOV = 6;
	localparam int DG_OUT_OV = 5;
	localparam int DG_IVCCUV = 4;
	localparam int DG_OPEN_LOAD = 3;
	localparam int DG_SHRT = 2;
	localparam int DG_OT_SHUT = 1;
	localparam int DG_OT_WARN = 0;
	// Number of latched fault inputs on the fault_event port
	localparam int NFAULT = 7;
	localparam logic [15:0] DIAG_IDLE_WORD = 16'h1000;
	localparam logic [1:0] STATE_ACTIVE = 2'h2;
	// Bank 0 register map held here
	localparam logic [5:0] ADDR_LAST_USED = 6'h0f;
	localparam logic [15:0] READ_FLAG = 16'h8000;
	// Timing of the host link
	localparam int SCLK_MIN_PERIOD_NS = 200;
	localparam int MCLK_PERIOD_NS = 5;
	localparam int SCLK_MIN_CYC = SCLK_MIN_PERIOD_NS / MCLK_PERIOD_NS;
endpackage

/* File: hw/sfd_sync.sv */
// Two-flop synchroniser for pins from the host.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ps
module sfd_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] INIT = '0
) (
	// System
	input wire logic mclk,
	input wire logic reset,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

/* File: hw/sfd_diag.sv */
// Diagnosis word builder: latched, clear-on-read and live bits.
// Assumes fault events are one-cycle or level inputs on mclk.
`timescale 1ns/1ps
module sfd_diag
	import sfd_pkg::*;
(
	// System
	input wire logic mclk,
	input wire logic reset,
	// Fault sources (supply_uv, vin_ov, out_ov, ivcc_uv, open_load, shorted, overtemp shutdown)
	input wire logic [NFAULT-1:0] fault_event,
	input wire logic softreset_event,
	input wire logic terr_event,
	// Live sources
	input wire logic gate_uv_live,
	input wire logic [1:0] op_state,
	input wire logic overtemp_warning_flag,
	input wire logic monitor_done_mirror,
	input wire logic fast_discharge_done_mirror,
	input wire logic calibration_done_mirror,
	input wire logic output_ov_latch_enable,
	// Controls
	input wire logic diag_read,
	input wire logic clear_latches_command,
	// Results
	output logic [15:0] standard_diagnosis,
	output logic protection_halt
);
	import sfd_pkg::*;

	logic [NFAULT-1:0] lat_q;
	logic softrst_q;
	logic xerr_q;
	logic [NFAULT-1:0] rd_clr;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		rd_clr = {NFAULT{diag_read}};
		rd_clr[6] = 1'b0;
		if (output_ov_latch_enable)
			rd_clr[2] = 1'b0;
	end

	// clear latches; set wins over clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			lat_q <= '0;
		end else begin
			lat_q <= (lat_q & ~rd_clr & {NFAULT{~clear_latches_command}}) | fault_event;
		end
	end

	// set at reset and on failed frame
	always_ff @(posedge mclk) begin
		if (reset) begin
			xerr_q <= 1'b1;
		end else begin
			xerr_q <= (xerr_q & ~diag_read & ~clear_latches_command) | terr_event;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			softrst_q <= 1'b0;
		end else begin
			softrst_q <= (softrst_q & ~diag_read) | softreset_event;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// word layout
	always_comb begin
		standard_diagnosis = '0;
		standard_diagnosis[DG_SOFTRST_GUV] = softrst_q | gate_uv_live;
		standard_diagnosis[DG_SUPPLY_UV] = lat_q[0];
		standard_diagnosis[DG_STATE_HI:DG_STATE_LO] = op_state;
		standard_diagnosis[DG_XFER_ERR] = xerr_q;
		standard_diagnosis[DG_MON] = monitor_done_mirror;
		standard_diagnosis[DG_MFS] = fast_discharge_done_mirror;
		standard_diagnosis[DG_CAL] = calibration_done_mirror;
		standard_diagnosis[DG_VINOV] = lat_q[1];
		standard_diagnosis[DG_OUT_OV] = lat_q[2];
		standard_diagnosis[DG_IVCCUV] = lat_q[3];
		standard_diagnosis[DG_OPEN_LOAD] = lat_q[4];
		standard_diagnosis[DG_SHRT] = lat_q[5];
		standard_diagnosis[DG_OT_SHUT] = lat_q[6];
		standard_diagnosis[DG_OT_WARN] = overtemp_warning_flag;
	end

	assign protection_halt = lat_q[6] | (lat_q[2] & output_ov_latch_enable);
endmodule

/* File: hw/sfd_spi_slave.sv */
// SPI slave frame handler with diagnosis word for an LED DC/DC controller.
// Assumes the host is SPI master; pins are sampled on mclk (200 MHz).
`timescale 1ns/1ps

// Overview of operation
// - Answer shifted now belongs to previous frame
// - Malformed frame answered with diagnosis word, transfer error bit set
// - First answer after undervoltage ignores old frames
// - Unused address answered with diagnosis word
// - Read answer MSB high, diagnosis MSB low
// - Answer frame may carry a new command
// - Fault flags latch, cleared by diagnosis read
// - Clear-latches resets flags and protections
// - Overtemp shutdown cleared only by command
// - Output overvoltage latched when enable set
// - State and temp warning are live
// - Routine done bits mirror internal bits
// - Soft-reset latch OR gate undervoltage
// - Idle healthy diagnosis word is 1000h
// - Serial input sampled on falling clock
// - Output released while chip select high, except for two cycles just after reset
// - Transfer error set after failure or reset
// - Sixteen-bit shift, act on select rising
module sfd_spi_slave
	import sfd_pkg::*;
#(
	parameter int NREG = 16
) (
	// System
	input wire logic mclk,
	input wire logic reset,
	// SPI pins
	input wire logic sclk,
	input wire logic chip_select_low_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// Undervoltage of enable input, asynchronous
	input wire logic en_uv,
	// Fault sources and live status
	input wire logic [NFAULT-1:0] fault_event,
	input wire logic gate_uv_live,
	input wire logic [1:0] op_state,
	input wire logic overtemp_warning_flag,
	input wire logic monitor_done_mirror,
	input wire logic fast_discharge_done_mirror,
	input wire logic calibration_done_mirror,
	// Command decoding results
	input wire logic [ADDR_W-1:0] clear_latches_addr,
	input wire logic [ADDR_W-1:0] softreset_addr,
	input wire logic [ADDR_W-1:0] switching_mode_addr,
	// Outputs toward the regulator
	output logic clear_latches_pulse,
	output logic software_reset_command,
	output logic protection_halt,
	output logic [DATA_W-1:0] switching_mode_register,
	output logic write_strobe,
	output logic [ADDR_W-1:0] write_addr,
	output logic [DATA_W-1:0] write_data
);
	import sfd_pkg::*;

	logic sclk_s, sel_s, sdi_s, enuv_s;
	logic sclk_d1_q, sel_d1_q;
	logic halt_c;
	logic [15:0] shift_q;
	logic [15:0] out_q;
	logic [7:0] cnt_q;
	logic [15:0] resp_q;
	logic [DATA_W-1:0] regs_q [NREG];
	logic diag_read, terr, softrst_ev, clr_ev;
	logic [15:0] diag_word;
	logic frame_end, fall_edge, rise_edge, start;
	logic bad_q;
	logic [DATA_W-1:0] swt_q;

	function automatic logic addr_used(input logic [ADDR_W-1:0] a);
		return a <= ADDR_LAST_USED;
	endfunction

	////////////////////////////////////////////////////////////////////////
	sfd_sync #(.W(4), .INIT(4'b0010)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in({sclk, chip_select_low_n, sdi, en_uv}),
		.sync_out({sclk_s, sel_s, sdi_s, enuv_s})
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			sclk_d1_q <= 1'b0;
			sel_d1_q <= 1'b1;
		end else begin
			sclk_d1_q <= sclk_s;
			sel_d1_q <= sel_s;
		end
	end

	assign start = sel_d1_q & ~sel_s;
	assign frame_end = ~sel_d1_q & sel_s;
	assign fall_edge = ~sel_s & sclk_d1_q & ~sclk_s;
	assign rise_edge = ~sel_s & ~sclk_d1_q & sclk_s;

	////////////////////////////////////////////////////////////////////////
	// sixteen-bit shift register
	always_ff @(posedge mclk) begin
		if (reset) begin
			shift_q <= '0;
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= '0;
		end else if (fall_edge) begin
			shift_q <= {shift_q[14:0], sdi_s};
			if (cnt_q != 8'hff)
				cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			out_q <= '0;
		end else if (start) begin
			out_q <= resp_q;
		end else if (fall_edge) begin
			out_q <= {out_q[14:0], 1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= ~sel_s;
			if (start)
				sdo <= resp_q[15];
			else if (rise_edge || fall_edge)
				sdo <= out_q[15];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// count must be multiple of 8, at least 16
	always_comb begin
		terr = frame_end && ((cnt_q[2:0] != 3'h0) || (cnt_q < 8'(FRAME_BITS)));
	end

	always_comb begin
		diag_read = 1'b0;
		softrst_ev = 1'b0;
		clr_ev = 1'b0;
		if (frame_end && !terr) begin
			diag_read = ~shift_q[POS_WR] & shift_q[POS_DIAG_REQ];
			if (shift_q[POS_WR] && !shift_q[POS_BANK]) begin
				clr_ev = shift_q[POS_ADDR_HI:POS_ADDR_LO] == clear_latches_addr;
				softrst_ev = shift_q[POS_ADDR_HI:POS_ADDR_LO] == softreset_addr;
			end
		end
	end

	sfd_diag u_diag (
		.mclk(mclk),
		.reset(reset),
		.fault_event(fault_event | {6'h00, 1'b0} | {{(NFAULT-1){1'b0}}, enuv_s}),
		.softreset_event(softrst_ev),
		.terr_event(terr),
		.gate_uv_live(gate_uv_live),
		.op_state(op_state),
		.overtemp_warning_flag(overtemp_warning_flag),
		.monitor_done_mirror(monitor_done_mirror),
		.fast_discharge_done_mirror(fast_discharge_done_mirror),
		.calibration_done_mirror(calibration_done_mirror),
		.output_ov_latch_enable(swt_q[0]),
		.diag_read(diag_read),
		.clear_latches_command(clr_ev),
		.standard_diagnosis(diag_word),
		.protection_halt(halt_c)
	);

	////////////////////////////////////////////////////////////////////////
	// valid bank-0 write frame stored when its address is used (0fh or below)
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < NREG; i++)
				regs_q[i] <= '0;
			swt_q <= '0;
		end else if (frame_end && !terr && shift_q[POS_WR] && !shift_q[POS_BANK]) begin
			if (addr_used(shift_q[POS_ADDR_HI:POS_ADDR_LO]))
				regs_q[shift_q[11:8]] <= shift_q[7:0];
			if (shift_q[POS_ADDR_HI:POS_ADDR_LO] == switching_mode_addr)
				swt_q <= shift_q[7:0];
		end
	end

	// Register each write for the regulator side
	always_ff @(posedge mclk) begin
		if (reset) begin
			write_strobe <= 1'b0;
			write_addr <= '0;
			write_data <= '0;
			clear_latches_pulse <= 1'b0;
			software_reset_command <= 1'b0;
			switching_mode_register <= '0;
			protection_halt <= 1'b0;
		end else begin
			protection_halt <= halt_c;
			write_strobe <= frame_end && !terr && shift_q[POS_WR] && !shift_q[POS_BANK];
			write_addr <= shift_q[POS_ADDR_HI:POS_ADDR_LO];
			write_data <= shift_q[7:0];
			clear_latches_pulse <= clr_ev;
			software_reset_command <= softrst_ev;
			switching_mode_register <= swt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answer frozen at frame end unless bad_q is set, before the read clears the latches
	always_ff @(posedge mclk) begin
		if (reset) begin
			bad_q <= 1'b1;
		end else if (enuv_s) begin
			bad_q <= 1'b1;
		end else if (frame_end) begin
			bad_q <= terr;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			resp_q <= '0;
		end else if (frame_end && !terr && !shift_q[POS_WR] && !shift_q[POS_DIAG_REQ]
				&& !shift_q[POS_BANK] && addr_used(shift_q[POS_ADDR_HI:POS_ADDR_LO])) begin
			resp_q <= READ_FLAG | {8'h00, regs_q[shift_q[11:8]]};
		end else if (frame_end) begin
			// writes, diagnosis requests, errors, unused address: diag MSB low, current diagnosis word
			resp_q <= diag_word;
			// error bit speaks of this frame
			resp_q[DG_XFER_ERR] <= terr;
		end else if (bad_q) begin
			resp_q <= diag_word;
		end
	end
endmodule

/* File: bench/sfd_chk.sv */
// Checker on the frame handler's top-level ports.
// Assumes binding to sfd_spi_slave with mclk and sync reset.
`timescale 1ns/1ps
module sfd_chk
	import sfd_pkg::*;
(
	// System
	input wire logic mclk,
	input wire logic reset,
	// Link and results
	input wire logic chip_select_low_n,
	input wire logic sdo_oe,
	input wire logic [NFAULT-1:0] fault_event,
	input wire logic clear_latches_pulse,
	input wire logic software_reset_command,
	input wire logic protection_halt,
	input wire logic [DATA_W-1:0] switching_mode_register,
	input wire logic write_strobe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// Synchroniser delay fits inside eight cycles
	sequence s_deselect;
		$rose(chip_select_low_n) ##1 chip_select_low_n [*7];
	endsequence
	chk_oe_released: assert property (s_deselect |=> !sdo_oe)
		else $error("sdo_oe high while deselected");
	chk_oe_driven: assert property ($fell(chip_select_low_n) |-> ##[1:8] sdo_oe)
		else $error("sdo_oe not raised");
	chk_strobe_pulse: assert property (write_strobe |=> !write_strobe)
		else $error("write strobe too long");
	chk_act_deselected: assert property (write_strobe |-> chip_select_low_n && $past(chip_select_low_n))
		else $error("write while selected");
	chk_no_act_busy: assert property (!chip_select_low_n [*8] |-> !write_strobe && !clear_latches_pulse)
		else $error("action during transfer");
	chk_clr_pulse: assert property (clear_latches_pulse |=> !clear_latches_pulse)
		else $error("clear pulse too long");
	chk_rst_pulse: assert property (software_reset_command |=> !software_reset_command)
		else $error("soft reset pulse too long");
	chk_halt_release: assert property (clear_latches_pulse && fault_event == '0 |-> ##[1:3] !protection_halt)
		else $error("halt kept after clear");
	chk_mode_by_write: assert property ($changed(switching_mode_register) |-> write_strobe || $past(write_strobe))
		else $error("mode changed without write");
endmodule
bind sfd_spi_slave sfd_chk sfd_chk_inst (.mclk(mclk), .reset(reset), .chip_select_low_n(chip_select_low_n),
	.sdo_oe(sdo_oe), .fault_event(fault_event), .clear_latches_pulse(clear_latches_pulse),
	.software_reset_command(software_reset_command), .protection_halt(protection_halt),
	.switching_mode_register(switching_mode_register), .write_strobe(write_strobe));

/* File: bench/sfd_host.sv */
// Host model: SPI master, clock idle low, MSB first.
// Assumes mclk for pacing; pins move on mclk falling edges.
`timescale 1ns/1ps
module sfd_host (
	// System
	input wire logic mclk,
	// SPI pins
	output logic sclk,
	output logic chip_select_low_n,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		chip_select_low_n = 1'b1;
		sdi = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge mclk);
		chip_select_low_n = 1'b0;
		repeat (32) @(negedge mclk);
		for (int i = 0; i < nbits; i++) begin
			// data held around the falling edge
			repeat (8) @(negedge mclk);
			sdi = tx[15 - i];
			repeat (8) @(negedge mclk);
			sclk = 1'b1;
			repeat (16) @(negedge mclk);
			rx = {rx[14:0], sdo};
			sclk = 1'b0;
		end
		// Data line driven low eight cycles after the last bit
		repeat (8) @(negedge mclk);
		sdi = 1'b0;
		repeat (32) @(negedge mclk);
		chip_select_low_n = 1'b1;
		repeat (60) @(negedge mclk);
	endtask
endmodule

/* File: bench/tb.sv */
// Testbench: diagnosis word and frame handling over SPI.
// Assumes the host model paces frames on mclk.
`timescale 1ns/1ps
module tb;
	import sfd_pkg::*;
	localparam logic [15:0] DREQ = 16'h0001;
	localparam logic [5:0] A_SWM = 6'h02;
	localparam logic [5:0] A_CLR = 6'h03;
	localparam logic [5:0] A_RST = 6'h04;
	localparam logic [15:0] FBIT [6] = '{16'h2000, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004};
	logic mclk, reset, sclk, chip_select_low_n, sdi, sdo, sdo_oe, en_uv, gate_uv_live;
	logic [NFAULT-1:0] fault_event;
	logic [1:0] op_state;
	logic overtemp_warning_flag, monitor_done_mirror, fast_discharge_done_mirror, calibration_done_mirror;
	logic clear_latches_pulse, software_reset_command, protection_halt, write_strobe;
	logic [DATA_W-1:0] switching_mode_register;
	logic [15:0] r, lat;
	int err_count, num_checks;
	////////////////////////////////////////////////////////////
	sfd_spi_slave sfd_spi_slave_inst (.mclk, .reset, .sclk, .chip_select_low_n, .sdi, .sdo, .sdo_oe, .en_uv,
		.fault_event, .gate_uv_live, .op_state, .overtemp_warning_flag, .monitor_done_mirror,
		.fast_discharge_done_mirror, .calibration_done_mirror, .clear_latches_addr(A_CLR),
		.softreset_addr(A_RST), .switching_mode_addr(A_SWM), .clear_latches_pulse, .software_reset_command,
		.protection_halt, .switching_mode_register, .write_strobe, .write_addr(), .write_data());
	sfd_host sfd_host_inst (.mclk, .sclk, .chip_select_low_n, .sdi, .sdo);
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;
	////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic xf(input logic [15:0] tx);
		sfd_host_inst.xfer(tx, 16, r);
	endtask
	task automatic pulse(input int i);
		@(negedge mclk);
		fault_event[i] = 1'b1;
		@(negedge mclk);
		fault_event[i] = 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Run is about 29k cycles
	initial begin
		repeat (80000) @(posedge mclk);
		err_count++;
		stop_test;
	end
	////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		en_uv = 1'b0;
		fault_event = '0;
		gate_uv_live = 1'b0;
		op_state = STATE_ACTIVE;
		{overtemp_warning_flag, monitor_done_mirror, fast_discharge_done_mirror, calibration_done_mirror} = 4'h0;
		err_count = 0;
		num_checks = 0;
		lat = 16'h0000;
		repeat (6) @(negedge mclk);
		reset = 1'b0;
		xf(DREQ);
		cmp("first", 16'h1400, r & 16'hdfff);
		xf(DREQ);
		cmp("idle", DIAG_IDLE_WORD, r);
		xf({2'b10, A_SWM, 8'h5b});
		cmp("mode", 16'h005b, {8'h00, switching_mode_register});
		xf({2'b00, A_SWM, 8'h00});
		xf(DREQ);
		cmp("read", 16'h805b, r & 16'h80ff);
		xf(DREQ);
		cmp("chained", DIAG_IDLE_WORD, r);
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			xf(DREQ);
			xf(DREQ);
			if (i == 2) begin
				lat = 16'h0020;
			end
			cmp("latched", DIAG_IDLE_WORD | lat | FBIT[i], r);
			xf(DREQ);
			cmp("cleared", DIAG_IDLE_WORD | lat, r);
		end
		pulse(6);
		xf(DREQ);
		xf(DREQ);
		cmp("shutdown", 16'h1022, r);
		cmp("halt", 16'h0001, {15'h0, protection_halt});
		xf(DREQ);
		cmp("shutdown kept", 16'h1022, r);
		xf({2'b10, A_CLR, 8'h00});
		xf(DREQ);
		xf(DREQ);
		cmp("clr", DIAG_IDLE_WORD, r);
		cmp("halt off", 16'h0000, {15'h0, protection_halt});
		sfd_host_inst.xfer(DREQ, 12, r);
		xf(DREQ);
		cmp("error", 16'h1400, r);
		xf({2'b00, 6'h20, 8'h00});
		xf(DREQ);
		cmp("unused", DIAG_IDLE_WORD, r);
		xf({2'b10, A_RST, 8'h00});
		xf(DREQ);
		xf(DREQ);
		cmp("softrst", 16'h4000, r & 16'h4000);
		xf(DREQ);
		cmp("softrst read", 16'h0000, r & 16'h4000);
		@(negedge mclk);
		op_state = 2'h3;
		gate_uv_live = 1'b1;
		{overtemp_warning_flag, monitor_done_mirror, fast_discharge_done_mirror, calibration_done_mirror} = 4'hf;
		xf(DREQ);
		xf(DREQ);
		cmp("live", 16'h5b81, r);
		xf({2'b10, A_CLR, 8'h00});
		xf(DREQ);
		xf(DREQ);
		cmp("live kept", 16'h5b81, r);
		@(negedge mclk);
		en_uv = 1'b1;
		repeat (20) @(negedge mclk);
		en_uv = 1'b0;
		repeat (20) @(negedge mclk);
		xf(DREQ);
		xf(DREQ);
		cmp("en uv", 16'h2000, r & 16'h2000);
		stop_test;
	end
endmodule
